// ===== rtl/aicr_defines.vh
`ifndef AICR_DEFINES_VH
`define AICR_DEFINES_VH
// ==========================================================
// Register offsets (byte addresses in I/O space)
`define AICR_OFF_START 4'h0
`define AICR_OFF_RES_HI 4'h1
`define AICR_OFF_SETUP 4'h2
`define AICR_OFF_SUBMUX 4'h3
`define AICR_OFF_OPTION 4'h4
`define AICR_OFF_GPIO 4'h5
`define AICR_OFF_TMR0 4'h8
`define AICR_OFF_TMR1 4'h9
`define AICR_OFF_TMR2 4'hA
`define AICR_OFF_TMRC 4'hB
// ==========================================================
// Converter setup fields
`define AICR_SETUP_CHAN_HI 7
`define AICR_SETUP_CHAN_LO 4
`define AICR_SETUP_PAIR 3
`define AICR_SETUP_RANGE_HI 2
`define AICR_SETUP_RANGE_LO 0
// ==========================================================
// Sub-mux output fields
`define AICR_SUBMUX_TAG_HI 7
`define AICR_SUBMUX_TAG_LO 4
`define AICR_SUBMUX_UNUSED 3
`define AICR_SUBMUX_GAIN_HI 2
`define AICR_SUBMUX_GAIN_LO 0
// ==========================================================
// Option control and status fields
`define AICR_OPT_TIMER_EN 0
`define AICR_OPT_IRQ_EN 2
`define AICR_OPT_PIN_EN 7
`define AICR_STAT_IDLE 7
`define AICR_STAT_PIN 0
// ==========================================================
// Result word
`define AICR_RES_TAG_HI 15
`define AICR_RES_TAG_LO 12
`define AICR_RES_DATA_HI 11
`define AICR_RES_DATA_LO 0
// ==========================================================
// Reset values
`define AICR_RST_SETUP 8'h00
`define AICR_RST_SUBMUX 8'h00
`define AICR_RST_OPTION 8'h00
`define AICR_RST_GPIO 4'h0
`define AICR_RST_RESULT 16'h0000
`endif

// ===== rtl/aicr_sync_rise.v
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Two-flop synchroniser with rising-edge detect
module aicr_sync_rise #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Asynchronous inputs
   input wire [W-1:0] d,
   // Synchronised level and one-cycle rise
   output wire [W-1:0] q,
   output wire [W-1:0] rise
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   reg [W-1:0] prev_q;

   always @(posedge clk)
   begin
      if (srst)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
         prev_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign q = sync_q;
   assign rise = sync_q & ~prev_q;
endmodule
`default_nettype wire

// ===== rtl/aicr_top.v
`timescale 1ns/10ps
`default_nettype none
`include "aicr_defines.vh"
module aicr_top (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Host I/O access
   input wire [3:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire io_word,
   input wire [15:0] io_wdata,
   output reg [15:0] io_rdata,
   output reg io_rack,
   // Attached interval timer, same clock
   output reg [1:0] tmr_addr,
   output reg tmr_wr,
   output reg tmr_rd,
   output reg [7:0] tmr_wdata,
   input wire [7:0] tmr_rdata,
   input wire timer_tc,
   // Converter
   output reg conv_start,
   input wire conv_done,
   input wire [11:0] conv_data,
   // Input path selection
   output wire [3:0] chan_sel,
   output wire pair_input_select,
   output wire [2:0] range_sel,
   // Sub-mux outputs
   output wire [3:0] tag_out,
   output wire [2:0] submux_gain,
   // External start pin
   input wire start_pin,
   // Open-collector lines
   input wire [3:0] gpio_i,
   output reg [3:0] gpio_o,
   output reg [3:0] gpio_oe_n,
   // Interrupt request
   output reg irq
);
   // ==========================================================
   // State
   reg [7:0] setup_q;
   reg [7:0] submux_q;
   reg timer_en_q;
   reg irq_en_q;
   reg pin_en_q;
   reg [3:0] gpio_drv_q;
   reg busy_q;
   reg [3:0] tag_cap_q;
   reg [15:0] result_q;
   reg tmr_pend_q;

   wire pin_lvl;
   wire pin_rise;
   wire done_lvl;
   wire done_rise;
   wire [3:0] gpio_lvl;

   // ==========================================================
   // Pin synchronisers
   aicr_sync_rise #(
      .W(1)
   ) u_pin_sync (
      .clk(clk),
      .srst(srst),
      .d(start_pin),
      .q(pin_lvl),
      .rise(pin_rise)
   );

   // Converter done may come from its own clock
   aicr_sync_rise #(
      .W(1)
   ) u_done_sync (
      .clk(clk),
      .srst(srst),
      .d(conv_done),
      .q(done_lvl),
      .rise(done_rise)
   );

   aicr_sync_rise #(
      .W(4)
   ) u_gpio_sync (
      .clk(clk),
      .srst(srst),
      .d(gpio_i),
      .q(gpio_lvl),
      .rise()
   );

   // ==========================================================
   // Address decode helpers
   // True when an access at a (byte or word) covers offset t.
   // Word accesses use an even address and cover a and a+1.
   function hit;
      input [3:0] a;
      input w;
      input [3:0] t;
      begin
         hit = (a == t) || (w && !a[0] && ({a[3:1], 1'b1} == t));
      end
   endfunction

   // Byte lane that carries offset t in a write
   function [7:0] lane;
      input [3:0] a;
      input [15:0] d;
      input [3:0] t;
      begin
         lane = (a == t) ? d[7:0] : d[15:8];
      end
   endfunction

   // Read value of one local offset
   function [7:0] rbyte;
      input [3:0] t;
      begin
         case (t)
            `AICR_OFF_START: rbyte = result_q[7:0];
            `AICR_OFF_RES_HI: rbyte = result_q[15:8];
            `AICR_OFF_SETUP: rbyte = setup_q;
            `AICR_OFF_SUBMUX: rbyte = {submux_q[7:4], 1'b0, submux_q[2:0]};
            `AICR_OFF_OPTION: rbyte = {~busy_q, 6'h00, pin_lvl};
            `AICR_OFF_GPIO: rbyte = {4'h0, gpio_lvl};
            default: rbyte = 8'h00;
         endcase
      end
   endfunction

   wire is_tmr = (io_addr[3:2] == 2'b10);
   wire wr_loc = io_wr && !is_tmr;
   wire rd_loc = io_rd && !is_tmr;
   localparam [7:0] RST_OPTION = `AICR_RST_OPTION;
   wire [7:0] opt_lane = lane(io_addr, io_wdata, `AICR_OFF_OPTION);
   wire [7:0] gpio_lane = lane(io_addr, io_wdata, `AICR_OFF_GPIO);

   wire sw_start = wr_loc && (io_addr == `AICR_OFF_START);
   wire tc_start = timer_en_q && timer_tc;
   wire pn_start = pin_en_q && pin_rise;
   wire any_start = sw_start || tc_start || pn_start;
   // Starts while busy are dropped so the result stays coherent
   wire take_start = any_start && !busy_q;

   wire stat_rd = rd_loc && hit(io_addr, io_word, `AICR_OFF_OPTION);
   wire irq_set = irq_en_q && busy_q && done_rise;

   // ==========================================================
   // Setup and sub-mux registers
   // setup fields drive the input path as soon as written
   always @(posedge clk)
   begin
      if (srst)
      begin
         setup_q <= `AICR_RST_SETUP;
         submux_q <= `AICR_RST_SUBMUX;
      end
      else
      begin
         if (wr_loc && hit(io_addr, io_word, `AICR_OFF_SETUP))
         begin
            setup_q <= lane(io_addr, io_wdata, `AICR_OFF_SETUP);
         end
         if (wr_loc && hit(io_addr, io_word, `AICR_OFF_SUBMUX))
         begin
            submux_q <= lane(io_addr, io_wdata, `AICR_OFF_SUBMUX) & 8'hF7;
         end
      end
   end

   assign chan_sel = setup_q[`AICR_SETUP_CHAN_HI:`AICR_SETUP_CHAN_LO];
   assign pair_input_select = setup_q[`AICR_SETUP_PAIR];
   assign range_sel = setup_q[`AICR_SETUP_RANGE_HI:`AICR_SETUP_RANGE_LO];
   assign tag_out = submux_q[`AICR_SUBMUX_TAG_HI:`AICR_SUBMUX_TAG_LO];
   assign submux_gain = submux_q[`AICR_SUBMUX_GAIN_HI:`AICR_SUBMUX_GAIN_LO];

   // ==========================================================
   // Option control and general-purpose lines
   // Other option bits are not stored; software keeps them zero
   always @(posedge clk)
   begin
      if (srst)
      begin
         timer_en_q <= RST_OPTION[`AICR_OPT_TIMER_EN];
         irq_en_q <= RST_OPTION[`AICR_OPT_IRQ_EN];
         pin_en_q <= RST_OPTION[`AICR_OPT_PIN_EN];
         gpio_drv_q <= `AICR_RST_GPIO;
      end
      else
      begin
         if (wr_loc && hit(io_addr, io_word, `AICR_OFF_OPTION))
         begin
            timer_en_q <= opt_lane[`AICR_OPT_TIMER_EN];
            irq_en_q <= opt_lane[`AICR_OPT_IRQ_EN];
            pin_en_q <= opt_lane[`AICR_OPT_PIN_EN];
         end
         if (wr_loc && hit(io_addr, io_word, `AICR_OFF_GPIO))
         begin
            gpio_drv_q <= gpio_lane[3:0];
         end
      end
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         gpio_o <= 4'h0;
         gpio_oe_n <= 4'hF;
      end
      else
      begin
         gpio_o <= 4'h0;
         gpio_oe_n <= ~gpio_drv_q;
      end
   end

   // ==========================================================
   // Conversion sequencing
   always @(posedge clk)
   begin
      if (srst)
      begin
         busy_q <= 1'b0;
         conv_start <= 1'b0;
         tag_cap_q <= 4'h0;
         result_q <= `AICR_RST_RESULT;
      end
      else
      begin
         conv_start <= take_start;
         if (take_start)
         begin
            busy_q <= 1'b1;
            tag_cap_q <= submux_q[`AICR_SUBMUX_TAG_HI:`AICR_SUBMUX_TAG_LO];
         end
         else if (busy_q && done_rise)
         begin
            busy_q <= 1'b0;
            result_q <= {tag_cap_q, conv_data};
         end
      end
   end

   // ==========================================================
   // Interrupt request
   // raise at conversion end
   always @(posedge clk)
   begin
      if (srst)
      begin
         irq <= 1'b0;
      end
      else if (irq_set)
      begin
         // New end of conversion beats a clearing status read
         irq <= 1'b1;
      end
      else if (stat_rd)
      begin
         irq <= 1'b0;
      end
   end

   // ==========================================================
   // Timer pass-through
   // Only the low byte of a timer access reaches the timer
   always @(posedge clk)
   begin
      if (srst)
      begin
         tmr_addr <= 2'b00;
         tmr_wr <= 1'b0;
         tmr_rd <= 1'b0;
         tmr_wdata <= 8'h00;
         tmr_pend_q <= 1'b0;
      end
      else
      begin
         tmr_wr <= io_wr && is_tmr;
         tmr_rd <= io_rd && is_tmr;
         tmr_pend_q <= io_rd && is_tmr;
         if ((io_wr || io_rd) && is_tmr)
         begin
            tmr_addr <= io_addr[1:0];
            tmr_wdata <= io_wdata[7:0];
         end
      end
   end

   // ==========================================================
   // Read data return
   // local register and timer readback
   always @(posedge clk)
   begin
      if (srst)
      begin
         io_rdata <= 16'h0000;
         io_rack <= 1'b0;
      end
      else if (tmr_pend_q)
      begin
         io_rdata <= {8'h00, tmr_rdata};
         io_rack <= 1'b1;
      end
      else if (rd_loc)
      begin
         if (io_word)
         begin
            io_rdata <= {rbyte({io_addr[3:1], 1'b1}), rbyte(io_addr)};
         end
         else
         begin
            io_rdata <= {8'h00, rbyte(io_addr)};
         end
         io_rack <= 1'b1;
      end
      else
      begin
         io_rack <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== dv/aicr_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks
module aicr_chk (
   // Clock, reset, host
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic io_word,
   input wire logic [15:0] io_wdata,
   input wire logic [15:0] io_rdata,
   input wire logic io_rack,
   // Far side
   input wire logic timer_tc,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [3:0] chan_sel,
   input wire logic pair_input_select,
   input wire logic [2:0] range_sel,
   input wire logic [3:0] tag_out,
   input wire logic [2:0] submux_gain,
   input wire logic [3:0] gpio_o,
   input wire logic [3:0] gpio_oe_n,
   input wire logic irq
);
   logic busy_q;
   logic [7:0] opt_q;
   logic [2:0] done_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // Busy view sets an edge after the design and clears with it; !conv_start covers the gap
   always @(posedge clk)
   begin
      done_q <= {done_q[1:0], conv_done};
      if (srst)
      begin
         busy_q <= 1'b0;
         opt_q <= 8'h00;
      end
      else
      begin
         if (conv_start)
            busy_q <= 1'b1;
         else if (done_q[1] && !done_q[2])
            busy_q <= 1'b0;
         if (io_wr && io_addr == 4'h4)
            opt_q <= io_wdata[7:0];
      end
   end
   sequence done_seen;
      busy_q && done_q[1] && !done_q[2];
   endsequence
   sequence status_read;
      io_rd && io_addr == 4'h4;
   endsequence
   chk_write_start: assert property (
      io_wr && io_addr == 4'h0 && !busy_q && !conv_start |=> conv_start)
      else $error("write at offset 0 started nothing");
   chk_offset1_inert: assert property (
      io_wr && io_addr == 4'h1 && !io_word |=>
      $stable({chan_sel, pair_input_select, range_sel, tag_out, submux_gain, gpio_oe_n}))
      else $error("write at offset 1 changed state");
   chk_setup_read: assert property (
      io_rd && io_addr == 4'h2 |=> io_rack && io_rdata ==
      {8'h00, $past(chan_sel), $past(pair_input_select), $past(range_sel)})
      else $error("setup readback wrong");
   chk_word_setup: assert property (
      io_wr && io_word && io_addr == 4'h2 |=>
      {chan_sel, pair_input_select, range_sel} == $past(io_wdata[7:0]) &&
      {tag_out, submux_gain} == {$past(io_wdata[15:12]), $past(io_wdata[10:8])})
      else $error("word write at offset 2 wrong");
   chk_irq_raise: assert property (
      done_seen ##0 opt_q[2] |-> ##[0:4] irq)
      else $error("no request at conversion end");
   chk_irq_clear: assert property (
      status_read ##0 (irq && !busy_q) |=> !irq)
      else $error("status read left request pending");
   // Drive register feeds the pin flop, so the pin lags the write by two edges
   chk_gpio_drive: assert property (
      io_wr && io_addr == 4'h5 |=> ##1 gpio_oe_n == ~$past(io_wdata[3:0], 2) && gpio_o == 4'h0)
      else $error("line drive wrong");
   chk_start_cause: assert property (
      $rose(conv_start) |-> $past(io_wr && io_addr == 4'h0) || $past(timer_tc) || opt_q[7])
      else $error("start without cause");
   chk_timer_start: assert property (
      timer_tc && opt_q[0] && !busy_q && !conv_start |=> conv_start)
      else $error("timer count did not start");
endmodule
bind aicr_top aicr_chk aicr_chk_i (
   .clk, .srst, .io_addr, .io_wr, .io_rd, .io_word, .io_wdata, .io_rdata, .io_rack,
   .timer_tc, .conv_start, .conv_done, .chan_sel, .pair_input_select, .range_sel,
   .tag_out, .submux_gain, .gpio_o, .gpio_oe_n, .irq);
`default_nettype wire

// ===== dv/aicr_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Converter, timer counter 2 and pulled-up lines
module aicr_far_model (
   // Clock and converter
   input wire logic clk,
   input wire logic conv_start,
   output logic conv_done,
   output logic [11:0] conv_data,
   // Timer
   input wire logic [1:0] tmr_addr,
   input wire logic tmr_rd,
   input wire logic tmr_wr,
   input wire logic [7:0] tmr_wdata,
   output logic [7:0] tmr_rdata,
   output logic timer_tc,
   // Lines and scenario control
   input wire logic [3:0] gpio_oe_n,
   output logic [3:0] gpio_i,
   input wire logic [11:0] next_val,
   input wire logic [7:0] lat
);
   logic [7:0] cnt;
   logic [7:0] t2;
   initial
   begin
      {conv_done, conv_data, cnt, t2, timer_tc} = 30'h0;
   end
   // Read data only valid while strobed
   assign tmr_rdata = tmr_rd ? t2 : ~t2;
   assign gpio_i = gpio_oe_n;
   always @(posedge clk)
   begin
      timer_tc <= 1'b0;
      if (tmr_wr && tmr_addr == 2'h2)
         t2 <= tmr_wdata;
      else if (t2 != 8'h00)
      begin
         t2 <= t2 - 8'h01;
         timer_tc <= t2 == 8'h01;
      end
      if (conv_start)
      begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         cnt <= lat;
      end
      else if (cnt != 8'h00)
      begin
         cnt <= cnt - 8'h01;
         if (cnt == 8'h01)
            {conv_done, conv_data} <= {1'b1, next_val};
      end
   end
endmodule
`default_nettype wire

// ===== dv/test_adc_card_control_registers.sv
`timescale 1ns/10ps
`default_nettype none
module test_adc_card_control_registers;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] io_addr = 4'h0;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic io_word = 1'b0;
   logic [15:0] io_wdata = 16'h0000;
   logic start_pin = 1'b0;
   logic [11:0] next_val = 12'h000;
   logic [7:0] lat = 8'h1E;
   logic [15:0] io_rdata, rv;
   logic [11:0] conv_data;
   logic [7:0] tmr_wdata, tmr_rdata;
   logic [3:0] chan_sel, tag_out, gpio_i, gpio_o, gpio_oe_n;
   logic [2:0] range_sel, submux_gain;
   logic [1:0] tmr_addr;
   logic io_rack, tmr_wr, tmr_rd, timer_tc, conv_start, conv_done, pair_input_select, irq;
   integer miscompares = 0;
   integer checked = 0;
   aicr_top aicr_top_i (.clk, .srst, .io_addr, .io_wr, .io_rd, .io_word, .io_wdata,
      .io_rdata, .io_rack, .tmr_addr, .tmr_wr, .tmr_rd, .tmr_wdata, .tmr_rdata, .timer_tc,
      .conv_start, .conv_done, .conv_data, .chan_sel, .pair_input_select, .range_sel,
      .tag_out, .submux_gain, .start_pin, .gpio_i, .gpio_o, .gpio_oe_n, .irq);
   aicr_far_model aicr_far_model_i (.clk, .conv_start, .conv_done, .conv_data, .tmr_addr,
      .tmr_rd, .tmr_wr, .tmr_wdata, .tmr_rdata, .timer_tc, .gpio_oe_n, .gpio_i, .next_val,
      .lat);
   always #2 clk = ~clk;
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic w);
      @(negedge clk);
      {io_addr, io_wdata, io_word, io_wr} = {a, d, w, 1'b1};
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic w);
      integer n;
      @(negedge clk);
      {io_addr, io_word, io_rd} = {a, w, 1'b1};
      @(negedge clk);
      io_rd = 1'b0;
      for (n = 0; n < 4 && io_rack !== 1'b1; n++)
         @(negedge clk);
      rv = io_rdata;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked = checked + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_idle;
      integer n;
      rd(4'h4, 1'b0);
      for (n = 0; n < 100 && rv[7] !== 1'b1; n++)
         rd(4'h4, 1'b0);
      chk("status", 16'h0080, rv);
   endtask
   task automatic wait_irq;
      integer n;
      for (n = 0; n < 80 && irq !== 1'b1; n++)
         @(negedge clk);
      chk("irq", 16'h0001, {15'h0000, irq});
      rd(4'h4, 1'b0);
      chk("irq", 16'h0000, {15'h0000, irq});
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #100000;
      miscompares = miscompares + 1;
      summarize;
   end
   initial
   begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      wr(4'h2, 16'hAF5B, 1'b1);
      wr(4'h1, 16'h00FF, 1'b0);
      rd(4'h2, 1'b0);
      chk("setup", 16'h005B, rv);
      rd(4'h3, 1'b0);
      chk("submux", 16'h00A7, rv);
      chk("path", 16'h5BA7, {chan_sel, pair_input_select, range_sel, tag_out, 1'b0,
         submux_gain});
      for (int i = 0; i < 16; i++)
      begin
         wr(4'h2, {8'h00, ~i[3], i[2:0], i[3], i[2:0]}, 1'b0);
         chk("range", {8'h00, ~i[3], i[2:0], i[3], i[2:0]},
            {8'h00, chan_sel, pair_input_select, range_sel});
      end
      wr(4'h2, 16'hA712, 1'b1);
      repeat (1750) @(negedge clk);
      next_val = 12'h9A5;
      wr(4'h0, 16'h0000, 1'b0);
      rd(4'h4, 1'b0);
      chk("status", 16'h0000, rv);
      wr(4'h3, 16'h0030, 1'b0);
      wait_idle;
      chk("irq", 16'h0000, {15'h0000, irq});
      rd(4'h0, 1'b1);
      chk("result", 16'hA9A5, rv);
      rd(4'h1, 1'b0);
      chk("result", 16'h00A9, rv);
      wr(4'h4, 16'h0004, 1'b0);
      {lat, next_val} = {8'h02, 12'h7FF};
      wr(4'h0, 16'h0000, 1'b0);
      wait_irq;
      rd(4'h0, 1'b1);
      chk("result", 16'h37FF, rv);
      start_pin = 1'b1;
      repeat (12) @(negedge clk);
      chk("irq", 16'h0000, {15'h0000, irq});
      rd(4'h4, 1'b0);
      chk("status", 16'h0081, rv);
      start_pin = 1'b0;
      wr(4'h4, 16'h0084, 1'b0);
      next_val = 12'h800;
      start_pin = 1'b1;
      wait_irq;
      rd(4'h0, 1'b1);
      chk("result", 16'h3800, rv);
      wr(4'h4, 16'h0005, 1'b0);
      next_val = 12'h123;
      wr(4'hA, 16'h0010, 1'b0);
      wait_irq;
      rd(4'h0, 1'b1);
      chk("result", 16'h3123, rv);
      rd(4'hA, 1'b0);
      chk("timer", 16'h0000, rv);
      wr(4'h5, 16'h0000, 1'b0);
      repeat (4) @(negedge clk);
      rd(4'h5, 1'b0);
      chk("lines", 16'h000F, rv);
      wr(4'h5, 16'h0005, 1'b0);
      repeat (4) @(negedge clk);
      rd(4'h5, 1'b0);
      chk("lines", 16'h000A, rv);
      rd(4'h6, 1'b0);
      chk("unmapped", 16'h0000, rv);
      summarize;
   end
endmodule
`default_nettype wire
